// ==== rtl/iau_pkg.sv ====
// Package: register map, instruction fields and decode helpers of the add unit
`default_nettype none
package iau_pkg;
    localparam int IAU_DW = 32;
    localparam int IAU_XLEN = 64;
    localparam int IAU_HALF = 32;
    localparam int IAU_IMM_W = 13;
    localparam int IAU_RIDX_W = 5;
    localparam int IAU_SUB_W = 6;
    localparam int IAU_FLAG_W = 8;
    localparam int IAU_ST_W = 2;
    // Register byte offsets
    localparam logic [7:0] IAU_OFF_INSN = 8'h00;
    localparam logic [7:0] IAU_OFF_SRCA_LO = 8'h04;
    localparam logic [7:0] IAU_OFF_SRCA_HI = 8'h08;
    localparam logic [7:0] IAU_OFF_SRCB_LO = 8'h0C;
    localparam logic [7:0] IAU_OFF_SRCB_HI = 8'h10;
    localparam logic [7:0] IAU_OFF_RES_LO = 8'h14;
    localparam logic [7:0] IAU_OFF_RES_HI = 8'h18;
    localparam logic [7:0] IAU_OFF_FLAGS = 8'h1C;
    localparam logic [7:0] IAU_OFF_STATUS = 8'h20;
    localparam logic [7:0] IAU_OFF_MASK = 8'h24;
    localparam logic [7:0] IAU_OFF_DECODE = 8'h28;
    // Instruction word fields
    localparam int IAU_MAJ_HI = 31;
    localparam int IAU_MAJ_LO = 30;
    localparam int IAU_RD_HI = 29;
    localparam int IAU_RD_LO = 25;
    localparam int IAU_SUB_HI = 24;
    localparam int IAU_SUB_LO = 19;
    localparam int IAU_RSA_HI = 18;
    localparam int IAU_RSA_LO = 14;
    localparam int IAU_ISEL = 13;
    localparam int IAU_IMM_HI = 12;
    localparam int IAU_IMM_LO = 0;
    localparam int IAU_RSV_HI = 12;
    localparam int IAU_RSV_LO = 5;
    localparam int IAU_RSB_HI = 4;
    localparam int IAU_RSB_LO = 0;
    localparam logic [1:0] IAU_MAJ_ARITH = 2'h2;
    localparam logic [5:0] IAU_SUB_ADD = 6'h00;
    localparam logic [5:0] IAU_SUB_ADDC = 6'h08;
    localparam logic [5:0] IAU_SUB_ADDCC = 6'h10;
    localparam logic [5:0] IAU_SUB_ADDCCC = 6'h18;
    // Condition flag layout: 64-bit set high nibble, 32-bit set low
    localparam int IAU_F_IC = 0;
    localparam int IAU_F_IV = 1;
    localparam int IAU_F_IZ = 2;
    localparam int IAU_F_IN = 3;
    localparam int IAU_F_XC = 4;
    localparam int IAU_F_XV = 5;
    localparam int IAU_F_XZ = 6;
    localparam int IAU_F_XN = 7;
    // Status and decode register layout
    localparam int IAU_ST_DONE = 0;
    localparam int IAU_ST_ILL = 1;
    localparam int IAU_DEC_RD_LO = 0;
    localparam int IAU_DEC_RSA_LO = 8;
    localparam int IAU_DEC_RSB_LO = 16;
    localparam int IAU_DEC_BUSY = 24;
    localparam logic [7:0] IAU_FLAG_RST = 8'h00;
    localparam logic [1:0] IAU_ST_RST = 2'h0;

    typedef enum logic [0:0] {
        IAU_S_IDLE = 1'b0,
        IAU_S_EXEC = 1'b1
    } iau_state_t;

    function automatic logic [63:0] iau_sext13(input logic [12:0] imm);
        return {{(IAU_XLEN - IAU_IMM_W){imm[IAU_IMM_W-1]}}, imm};
    endfunction

    function automatic logic iau_is_add(input logic [5:0] sub);
        return sub == IAU_SUB_ADD || sub == IAU_SUB_ADDC ||
               sub == IAU_SUB_ADDCC || sub == IAU_SUB_ADDCCC;
    endfunction

    function automatic logic iau_uses_carry(input logic [5:0] sub);
        return sub == IAU_SUB_ADDC || sub == IAU_SUB_ADDCCC;
    endfunction

    function automatic logic iau_sets_flags(input logic [5:0] sub);
        return sub == IAU_SUB_ADDCC || sub == IAU_SUB_ADDCCC;
    endfunction
endpackage
`default_nettype wire

// ==== rtl/iau_add_if.sv ====
// Interface: operands to and sum and flags from the adder slice
`timescale 1ns/1ps
`default_nettype none
interface iau_add_if;
    logic [63:0] op_a;
    logic [63:0] op_b;
    logic carry_in;
    logic [63:0] sum;
    logic [7:0] flags;
    modport req (output op_a, output op_b, output carry_in,
                 input sum, input flags);
    modport calc (input op_a, input op_b, input carry_in,
                  output sum, output flags);
endinterface
`default_nettype wire

// ==== rtl/iau_adder.sv ====
// Combinational 64-bit adder with both condition flag sets
`timescale 1ns/1ps
`default_nettype none
module iau_adder (
    iau_add_if.calc add_bus // Operands in, sum and flags out
);
    import iau_pkg::*;

    function automatic logic ovf(input logic sa, input logic sb,
                                 input logic ss);
        return (sa == sb) && (ss != sa);
    endfunction

    logic [IAU_HALF:0] lo_sum;
    logic [IAU_HALF:0] hi_sum;
    logic [63:0] s;

    // Split at bit 31 so the low carry is visible without a 2nd adder
    always_comb begin
        lo_sum = {1'b0, add_bus.op_a[IAU_HALF-1:0]}
               + {1'b0, add_bus.op_b[IAU_HALF-1:0]}
               + {{IAU_HALF{1'b0}}, add_bus.carry_in};
        hi_sum = {1'b0, add_bus.op_a[IAU_XLEN-1:IAU_HALF]}
               + {1'b0, add_bus.op_b[IAU_XLEN-1:IAU_HALF]}
               + {{IAU_HALF{1'b0}}, lo_sum[IAU_HALF]};
    end

    // Carry out of bit 63 leaves only through the flag
    assign s = {hi_sum[IAU_HALF-1:0], lo_sum[IAU_HALF-1:0]};
    assign add_bus.sum = s;

    always_comb begin
        add_bus.flags = IAU_FLAG_RST;
        add_bus.flags[IAU_F_IN] = s[IAU_HALF-1];
        add_bus.flags[IAU_F_XN] = s[IAU_XLEN-1];
        add_bus.flags[IAU_F_IZ] = s[IAU_HALF-1:0] == '0;
        add_bus.flags[IAU_F_XZ] = s == '0;
        add_bus.flags[IAU_F_IC] = lo_sum[IAU_HALF];
        add_bus.flags[IAU_F_XC] = hi_sum[IAU_HALF];
        add_bus.flags[IAU_F_IV] = ovf(add_bus.op_a[IAU_HALF-1],
            add_bus.op_b[IAU_HALF-1], s[IAU_HALF-1]);
        add_bus.flags[IAU_F_XV] = ovf(add_bus.op_a[IAU_XLEN-1],
            add_bus.op_b[IAU_XLEN-1], s[IAU_XLEN-1]);
    end
endmodule
`default_nettype wire

// ==== rtl/iau_add_unit.sv ====
// Integer add unit: APB registers, instruction decode, flags, interrupt
//
// Overview of operation
// - Decode opcode, destination, sub-opcode, sources, select bit, immediate.
// - Sub-opcodes 00 0000 add, 00 1000 add-with-carry; flags untouched.
// - Sub-opcodes 01 0000 and 01 1000 are the flag-setting variants.
// - Select bit 0: add both source registers into destination.
// - Select bit 1: add source A and sign-extended 13-bit immediate.
// - Carry variants add the 32-bit set carry, never the 64-bit one.
// - Only flag-setting variants write both flag sets from the result.
// - Overflow when operand signs agree and sum sign differs, per width.
// - Select bit 0 with bits 12:5 nonzero raises illegal instruction.
// - Unimplemented instructions raise only illegal instruction, nothing else.
// - Negative flags take result bit 31 and bit 63.
// - Zero flags set when bits 31:0, or all 64 bits, are zero.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module iau_add_unit #(
    parameter int AW = 8
) (
    input wire logic pclk, // APB clock, 10 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [AW-1:0] paddr, // APB byte address
    input wire logic [iau_pkg::IAU_DW-1:0] pwdata, // APB write data
    output logic [iau_pkg::IAU_DW-1:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic irq, // Level interrupt
    output logic add_done, // One-cycle pulse, add completed
    output logic illegal_trap // One-cycle pulse, illegal instruction
);
    import iau_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State and registers

    iau_state_t state_q;
    iau_state_t state_d;
    logic [IAU_DW-1:0] insn_q;
    logic [63:0] srca_q;
    logic [63:0] srcb_q;
    logic [63:0] res_q;
    logic [7:0] flag_q;
    logic [IAU_ST_W-1:0] status_q;
    logic [IAU_ST_W-1:0] mask_q;
    logic [IAU_RIDX_W-1:0] dest_q;
    logic [IAU_DW-1:0] prdata_q;
    logic add_done_q;
    logic illegal_q;

    logic wr_en;
    logic hit;
    logic [IAU_DW-1:0] rd_d;
    logic exec;
    logic [1:0] major;
    logic [5:0] sub;
    logic isel;
    logic rsv_bad;
    logic legal;
    logic setcc;
    logic [63:0] opnd_b;
    logic carry_in;
    logic [IAU_ST_W-1:0] st_set;
    logic [IAU_ST_W-1:0] st_clr;

    iau_add_if add_bus ();

    iau_adder u_adder (
        .add_bus(add_bus)
    );

    ////////////////////////////////////////////////////////////////////
    // Decode

    assign exec = state_q == IAU_S_EXEC;
    assign major = insn_q[IAU_MAJ_HI:IAU_MAJ_LO];
    assign sub = insn_q[IAU_SUB_HI:IAU_SUB_LO];
    assign isel = insn_q[IAU_ISEL];
    // Reserved bits only matter in register form
    assign rsv_bad = !isel && (insn_q[IAU_RSV_HI:IAU_RSV_LO] != '0);
    // Anything outside the four add forms is unimplemented here
    assign legal = major == IAU_MAJ_ARITH && iau_is_add(sub) && !rsv_bad;
    assign setcc = iau_sets_flags(sub);
    assign opnd_b = isel ? iau_sext13(insn_q[IAU_IMM_HI:IAU_IMM_LO])
                         : srcb_q;
    assign carry_in = iau_uses_carry(sub) && flag_q[IAU_F_IC];

    assign add_bus.op_a = srca_q;
    assign add_bus.op_b = opnd_b;
    assign add_bus.carry_in = carry_in;

    ////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data sampled in setup

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite && hit;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_q;

    always_comb begin
        hit = 1'b1;
        rd_d = '0;
        case (paddr[7:0])
            IAU_OFF_INSN: rd_d = insn_q;
            IAU_OFF_SRCA_LO: rd_d = srca_q[IAU_HALF-1:0];
            IAU_OFF_SRCA_HI: rd_d = srca_q[IAU_XLEN-1:IAU_HALF];
            IAU_OFF_SRCB_LO: rd_d = srcb_q[IAU_HALF-1:0];
            IAU_OFF_SRCB_HI: rd_d = srcb_q[IAU_XLEN-1:IAU_HALF];
            IAU_OFF_RES_LO: rd_d = res_q[IAU_HALF-1:0];
            IAU_OFF_RES_HI: rd_d = res_q[IAU_XLEN-1:IAU_HALF];
            IAU_OFF_FLAGS: rd_d[IAU_FLAG_W-1:0] = flag_q;
            IAU_OFF_STATUS: rd_d[IAU_ST_W-1:0] = status_q;
            IAU_OFF_MASK: rd_d[IAU_ST_W-1:0] = mask_q;
            IAU_OFF_DECODE: begin
                rd_d[IAU_DEC_RD_LO +: IAU_RIDX_W] = dest_q;
                rd_d[IAU_DEC_RSA_LO +: IAU_RIDX_W] =
                    insn_q[IAU_RSA_HI:IAU_RSA_LO];
                rd_d[IAU_DEC_RSB_LO +: IAU_RIDX_W] =
                    insn_q[IAU_RSB_HI:IAU_RSB_LO];
                rd_d[IAU_DEC_BUSY] = exec;
            end
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer: an instruction write runs one execute cycle

    always_comb begin
        case (state_q)
            IAU_S_IDLE: begin
                state_d = (wr_en && paddr[7:0] == IAU_OFF_INSN)
                        ? IAU_S_EXEC : IAU_S_IDLE;
            end
            IAU_S_EXEC: state_d = IAU_S_IDLE;
            default: state_d = IAU_S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= IAU_S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Software-written instruction, operands and interrupt mask

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insn_q <= '0;
            srca_q <= '0;
            srcb_q <= '0;
            mask_q <= IAU_ST_RST;
        end else if (wr_en) begin
            case (paddr[7:0])
                IAU_OFF_INSN: insn_q <= pwdata;
                IAU_OFF_SRCA_LO: srca_q[IAU_HALF-1:0] <= pwdata;
                IAU_OFF_SRCA_HI: srca_q[IAU_XLEN-1:IAU_HALF] <= pwdata;
                IAU_OFF_SRCB_LO: srcb_q[IAU_HALF-1:0] <= pwdata;
                IAU_OFF_SRCB_HI: srcb_q[IAU_XLEN-1:IAU_HALF] <= pwdata;
                IAU_OFF_MASK: mask_q <= pwdata[IAU_ST_W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Result and destination, legal adds only

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_q <= '0;
            dest_q <= '0;
        end else if (exec && legal) begin
            res_q <= add_bus.sum;
            dest_q <= insn_q[IAU_RD_HI:IAU_RD_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Condition flags: hardware update beats a software write

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= IAU_FLAG_RST;
        end else if (exec && legal && setcc) begin
            flag_q <= add_bus.flags;
        end else if (wr_en && paddr[7:0] == IAU_OFF_FLAGS) begin
            flag_q <= pwdata[IAU_FLAG_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status, interrupt and event pulses

    always_comb begin
        st_set = '0;
        st_set[IAU_ST_DONE] = exec && legal;
        st_set[IAU_ST_ILL] = exec && !legal;
        st_clr = (wr_en && paddr[7:0] == IAU_OFF_STATUS)
               ? pwdata[IAU_ST_W-1:0] : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= IAU_ST_RST;
        end else begin
            // A new event in the clearing cycle survives
            status_q <= (status_q & ~st_clr) | st_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            add_done_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            add_done_q <= st_set[IAU_ST_DONE];
            illegal_q <= st_set[IAU_ST_ILL];
        end
    end

    assign add_done = add_done_q;
    assign illegal_trap = illegal_q;
    assign irq = |(status_q & mask_q);

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [IAU_XLEN:0] exp_wide;
    assign exp_wide = {1'b0, srca_q} + {1'b0, opnd_b}
                    + {{IAU_XLEN{1'b0}}, carry_in};

    logic [IAU_HALF:0] exp_lo;
    assign exp_lo = {1'b0, srca_q[IAU_HALF-1:0]}
                  + {1'b0, opnd_b[IAU_HALF-1:0]}
                  + {{IAU_HALF{1'b0}}, carry_in};

    a_reg_form_sum: assert property (
        exec && legal && !isel |=>
            res_q == $past(srca_q) + $past(srcb_q)
                   + {{(IAU_XLEN-1){1'b0}}, $past(carry_in)})
        else $error("register form sum wrong");

    a_imm_form_sum: assert property (
        exec && legal && isel |=>
            res_q == $past(srca_q)
                   + iau_sext13($past(insn_q[IAU_IMM_HI:IAU_IMM_LO]))
                   + {{(IAU_XLEN-1){1'b0}}, $past(carry_in)})
        else $error("immediate form sum wrong");

    a_carry_in_source: assert property (
        exec && legal && !iau_uses_carry(sub) |=>
            res_q == $past(srca_q) + $past(opnd_b))
        else $error("carry added by plain add");

    a_plain_keeps_flags: assert property (
        exec && legal && !setcc
            && !(wr_en && paddr[7:0] == IAU_OFF_FLAGS) |=> $stable(flag_q))
        else $error("plain add changed flags");

    a_neg_zero_flags: assert property (
        exec && legal && setcc |=>
            flag_q[IAU_F_IN] == res_q[IAU_HALF-1]
            && flag_q[IAU_F_XN] == res_q[IAU_XLEN-1]
            && flag_q[IAU_F_IZ] == (res_q[IAU_HALF-1:0] == '0)
            && flag_q[IAU_F_XZ] == (res_q == '0))
        else $error("negative or zero flag wrong");

    a_carry_out_64: assert property (
        exec && legal && setcc |=>
            {flag_q[IAU_F_XC], res_q} == $past(exp_wide))
        else $error("64-bit carry or sum wrong");

    a_overflow_64: assert property (
        exec && legal && setcc |=>
            flag_q[IAU_F_XV] == ($past(srca_q[IAU_XLEN-1])
                == $past(opnd_b[IAU_XLEN-1])
                && res_q[IAU_XLEN-1] != $past(srca_q[IAU_XLEN-1])))
        else $error("64-bit overflow wrong");

    a_carry_out_32: assert property (
        exec && legal && setcc |=>
            flag_q[IAU_F_IC] == $past(exp_lo[IAU_HALF]))
        else $error("32-bit carry flag wrong");

    a_overflow_32: assert property (
        exec && legal && setcc |=>
            flag_q[IAU_F_IV] == ($past(srca_q[IAU_HALF-1])
                == $past(opnd_b[IAU_HALF-1])
                && res_q[IAU_HALF-1] != $past(srca_q[IAU_HALF-1])))
        else $error("32-bit overflow wrong");

    a_illegal_flags: assert property (
        exec && !legal && !(wr_en && paddr[7:0] == IAU_OFF_FLAGS)
            |=> $stable(flag_q))
        else $error("illegal instruction changed flags");

    a_status_clear: assert property (
        wr_en && paddr[7:0] == IAU_OFF_STATUS && !exec |=>
            (status_q & $past(pwdata[IAU_ST_W-1:0])) == '0)
        else $error("status bit not cleared");

    a_done_pulse: assert property (
        add_done |=> !add_done)
        else $error("done pulse lasted more than one cycle");

    a_reserved_trap: assert property (
        exec && rsv_bad |=> illegal_trap && status_q[IAU_ST_ILL]
            && !add_done)
        else $error("reserved bits not trapped");

    a_illegal_quiet: assert property (
        exec && !legal |=> $stable(res_q) && $stable(dest_q)
            && !add_done ##1 !illegal_trap)
        else $error("illegal instruction had side effects");

    a_exec_one_cycle: assert property (
        exec |=> !exec)
        else $error("execute lasted more than one cycle");

    a_irq_follows: assert property (
        exec && !legal && mask_q[IAU_ST_ILL] |=> irq)
        else $error("masked-in event did not interrupt");

    c_plain_add: cover property (exec && legal && sub == IAU_SUB_ADD);
    c_addc_flags: cover property (exec && legal && sub == IAU_SUB_ADDCCC
        && flag_q[IAU_F_IC]);
    c_reserved: cover property (exec && rsv_bad);
    c_irq_clear: cover property (irq ##[1:20] !irq);
endmodule
`default_nettype wire

// ==== testbench/iau_insn_src.sv ====
// Model of the instruction source: encodes add words for the unit
`timescale 1ns/1ps
`default_nettype none
module iau_insn_src (
    input wire logic [5:0] sub, // Sub-opcode
    input wire logic [4:0] rd, // Destination index
    input wire logic [4:0] rsa, // Source A index
    input wire logic [4:0] rsb, // Source B index
    input wire logic isel, // Immediate select
    input wire logic [12:0] imm, // Signed immediate
    output logic [31:0] word // Encoded instruction word
);
    import iau_pkg::*;
    // Register form keeps bits 12:5 zero
    assign word = {IAU_MAJ_ARITH, rd, sub, rsa, isel,
                   isel ? imm : {8'h00, rsb}};
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Testbench of the add unit: APB driver, random and corner adds
`timescale 1ns/1ps
`default_nettype none
module tb;
    import iau_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, irq, add_done, illegal_trap;
    logic [5:0] f_sub = 6'h00;
    logic [4:0] f_rd = 5'h00;
    logic [4:0] f_rsa = 5'h00;
    logic [4:0] f_rsb = 5'h00;
    logic f_isel = 1'b0;
    logic [12:0] f_imm = 13'h0000;
    logic [31:0] insn;
    logic [31:0] rdat;
    logic err;
    int n_errors = 0;
    int checked = 0;
    logic [5:0] subs [4] = '{IAU_SUB_ADD, IAU_SUB_ADDC, IAU_SUB_ADDCC,
                             IAU_SUB_ADDCCC};
    logic [7:0] regs [5] = '{IAU_OFF_FLAGS, IAU_OFF_STATUS, IAU_OFF_MASK,
                             IAU_OFF_RES_LO, IAU_OFF_RES_HI};
    logic [63:0] ca [4] = '{64'hFFFF_FFFF_FFFF_FFFF, 64'h0000_0000_7FFF_FFFF,
                            64'h7FFF_FFFF_FFFF_FFFF, 64'h0000_0000_0000_0000};
    logic [63:0] cb [4] = '{64'h0000_0000_0000_0001, 64'h0000_0000_0000_0001,
                            64'h0000_0000_0000_0001, 64'h0000_0000_0000_0000};

    always #50 pclk = ~pclk;

    iau_add_unit #(.AW(8)) iau_add_unit_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .add_done(add_done), .illegal_trap(illegal_trap)
    );

    iau_insn_src iau_insn_src_i (
        .sub(f_sub), .rd(f_rd), .rsa(f_rsa), .rsb(f_rsb),
        .isel(f_isel), .imm(f_imm), .word(insn)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk32(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask

    // Request held until pready is seen high; no wait count assumed
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            n_errors++;
            stop_test();
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk32(nm, e, rdat);
    endtask

    // Returns {illegal_trap, add_done} at the first pulse seen
    task automatic exec(input logic [31:0] w, output logic [1:0] pul);
        int n;
        apb(1'b1, IAU_OFF_INSN, w);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            pul = {illegal_trap, add_done};
        end while (pul == 2'b00 && n < 16);
        if (n >= 16) begin
            n_errors++;
            stop_test();
        end
    endtask

    // Returns {sum, flags}; flags kept when the variant leaves them
    function automatic logic [71:0] exp_add(input logic [63:0] a,
        input logic [63:0] b, input logic cin, input logic [7:0] fin,
        input logic setf);
        logic [64:0] s;
        logic [32:0] lo;
        logic [7:0] f;
        s = {1'b0, a} + {1'b0, b} + 65'(cin);
        lo = {1'b0, a[31:0]} + {1'b0, b[31:0]} + 33'(cin);
        f[0] = lo[32];
        f[1] = (a[31] == b[31]) && (s[31] != a[31]);
        f[2] = (s[31:0] == 32'h0000_0000);
        f[3] = s[31];
        f[4] = s[64];
        f[5] = (a[63] == b[63]) && (s[63] != a[63]);
        f[6] = (s[63:0] == 64'h0000_0000_0000_0000);
        f[7] = s[63];
        return {s[63:0], setf ? f : fin};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [63:0] a;
        logic [63:0] b;
        logic [63:0] bo;
        logic [71:0] ex;
        logic [7:0] fl;
        logic [1:0] pul;
        logic [31:0] w;
        void'($urandom(48379));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            rchk("reset value", regs[k], 32'h0000_0000);
        end
        chk1("mapped error", 1'b0, err);
        chk1("irq after reset", 1'b0, irq);
        $display("test reset done");
        rchk("unmapped read", 8'h40, 32'h0000_0000);
        chk1("unmapped error", 1'b1, err);
        apb(1'b1, IAU_OFF_RES_LO, 32'hFFFF_FFFF);
        rchk("read-only result", IAU_OFF_RES_LO, 32'h0000_0000);
        $display("test bus errors done");
        for (int i = 0; i < 40; i++) begin
            f_sub = subs[i % 4];
            f_isel = (i < 8) ? 1'b0 : 1'($urandom % 2);
            a = (i < 8) ? ca[i / 2] : {$urandom, $urandom};
            b = (i < 8) ? cb[i / 2] : {$urandom, $urandom};
            // Only one carry set per corner, so a wrong carry source shows
            fl = (i < 8) ? (i[1] ? 8'h01 : 8'h10) : 8'($urandom);
            f_imm = 13'($urandom);
            f_rd = 5'($urandom);
            f_rsa = 5'($urandom);
            f_rsb = 5'($urandom);
            #1;
            bo = f_isel ? {{51{f_imm[12]}}, f_imm} : b;
            ex = exp_add(a, bo, f_sub[3] & fl[0], fl, f_sub[4]);
            apb(1'b1, IAU_OFF_FLAGS, 32'(fl));
            apb(1'b1, IAU_OFF_SRCA_LO, a[31:0]);
            apb(1'b1, IAU_OFF_SRCA_HI, a[63:32]);
            apb(1'b1, IAU_OFF_SRCB_LO, b[31:0]);
            apb(1'b1, IAU_OFF_SRCB_HI, b[63:32]);
            exec(insn, pul);
            chk32("pulse pair", 32'h0000_0001, 32'(pul));
            rchk("result low", IAU_OFF_RES_LO, ex[39:8]);
            rchk("result high", IAU_OFF_RES_HI, ex[71:40]);
            rchk("flags", IAU_OFF_FLAGS, 32'(ex[7:0]));
            rchk("status", IAU_OFF_STATUS, 32'h0000_0001);
            apb(1'b0, IAU_OFF_DECODE, 32'h0000_0000);
            // Source B index field carries immediate bits in immediate form
            w = {8'h00, 3'h0, (f_isel ? f_imm[4:0] : f_rsb), 3'h0, f_rsa,
                 3'h0, f_rd};
            chk32("decode", w, rdat);
            apb(1'b1, IAU_OFF_STATUS, 32'h0000_0003);
        end
        $display("test random adds done");
        for (int k = 0; k < 6; k++) begin
            f_sub = subs[k % 4];
            f_isel = 1'b0;
            #1;
            w = insn;
            if (k < 4) begin
                w[12:5] = (k == 0) ? 8'h80 : (8'($urandom) | 8'h01);
            end else if (k == 4) begin
                w[24:19] = 6'h01;
            end else begin
                w[31:30] = 2'h0;
            end
            exec(w, pul);
            chk32("pulse pair", 32'h0000_0002, 32'(pul));
            rchk("kept result low", IAU_OFF_RES_LO, ex[39:8]);
            rchk("kept result high", IAU_OFF_RES_HI, ex[71:40]);
            rchk("kept flags", IAU_OFF_FLAGS, 32'(ex[7:0]));
            rchk("status", IAU_OFF_STATUS, 32'h0000_0002);
            apb(1'b1, IAU_OFF_STATUS, 32'h0000_0003);
        end
        $display("test illegal words done");
        apb(1'b1, IAU_OFF_MASK, 32'h0000_0001);
        f_sub = IAU_SUB_ADD;
        #1;
        exec(insn, pul);
        rchk("status", IAU_OFF_STATUS, 32'h0000_0001);
        chk1("irq done unmasked", 1'b1, irq);
        apb(1'b1, IAU_OFF_STATUS, 32'h0000_0001);
        rchk("status cleared", IAU_OFF_STATUS, 32'h0000_0000);
        chk1("irq cleared", 1'b0, irq);
        apb(1'b1, IAU_OFF_MASK, 32'h0000_0002);
        exec(insn, pul);
        rchk("mask", IAU_OFF_MASK, 32'h0000_0002);
        chk1("irq done masked", 1'b0, irq);
        exec(insn | 32'h0000_0020, pul);
        rchk("status", IAU_OFF_STATUS, 32'h0000_0003);
        chk1("irq illegal", 1'b1, irq);
        apb(1'b1, IAU_OFF_STATUS, 32'h0000_0003);
        rchk("status cleared", IAU_OFF_STATUS, 32'h0000_0000);
        chk1("irq cleared", 1'b0, irq);
        $display("test interrupts done");
        stop_test();
    end
endmodule
`default_nettype wire
